// File: design/edl_map.svh
`ifndef EDL_MAP_SVH
`define EDL_MAP_SVH
// Register word addresses
`define EDL_ADDR_CTRL_A 6'h06
`define EDL_ADDR_CTRL_B 6'h07
`define EDL_ADDR_SYNTH_INT 6'h0f
`define EDL_ADDR_SYNTH_FRAC 6'h10
`define EDL_ADDR_TX_LEVEL 6'h12
`define EDL_ADDR_IRQ_STATUS 6'h24
`define EDL_ADDR_RX_LATCH 6'h2d
`define EDL_ADDR_STREAM_TUNE 6'h38
// Field positions
`define EDL_SEQ_LSB 0
`define EDL_ALGO_LSB 4
`define EDL_CMPL_EN_BIT 10
`define EDL_STREAM_EN_BIT 5
`define EDL_BUSY_BIT 1
`define EDL_CMPL_BIT 5
`define EDL_POWER_LSB 8
// Field codes
`define EDL_SEQ_MEASURE 2'h1
`define EDL_ALGO_ENERGY 2'h2
// Reset values
`define EDL_RST_TX_LEVEL 16'h00bc
`define EDL_RST_STREAM_TUNE 16'h0008
`define EDL_RST_ZERO 16'h0000
// Timing
`define EDL_CLK_MHZ 25
`define EDL_WARM_US 144
`define EDL_SYMBOL_US 16
`define EDL_AVG_SYMBOLS 8
`define EDL_WARM_CYC (`EDL_WARM_US * `EDL_CLK_MHZ)
`define EDL_SYMBOL_CYC (`EDL_SYMBOL_US * `EDL_CLK_MHZ)
`endif

// File: design/edl_pkg.sv
`default_nettype none
package edl_pkg;
  typedef enum logic [1:0] {
    EDL_IDLE,
    EDL_WARM,
    EDL_AVERAGE,
    EDL_DONE
  } edl_state_t;
  // One finished packet report from the receive path
  typedef struct packed {
    logic [7:0] quality;
    logic [6:0] length;
  } edl_rx_report_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } edl_reg_req_t;
endpackage
`default_nettype wire

// File: design/edl_top.sv
// Behaviour
// [R1] Warm 144 us, then average eight symbols
// [R2] Energy mode stores average, no threshold compare
// [R3] Busy-channel flag untouched by energy detect
// [R4] Completion sets status bit 5
// [R5] Interrupt only when control bit 10 set
// [R6] Algorithm field 10 selects energy detect
// [R7] Host selects sequence 1, holds enable high
// [R8] Host lowers enable before configuring
// [R9] Host programs channel before measuring
// [R10] Host reads result, then lowers enable
// [R11] Host clears streaming bit before measuring
// [R12] Streaming kept: host writes 0x01ff first
// [R13] Host restores 0x0008 before receiving
// [R14] Packet quality lands in result bits 15:8
// [R15] Quality read together with length latch
// [R16] Result is half-dBm unsigned magnitude
// [R17] Host scales quality to 0..255
// [R18] Host programs integer and fraction dividers
// [R19] Level register: four fields, resets 0xbc
// [R20] Host keeps low nibble at 0xc
// [R21] Status read clears set flags
`include "edl_map.svh"
`timescale 1ns/10ps
`default_nettype none
module edl_top #(
  parameter int unsigned WARM_CYC = `EDL_WARM_CYC,
  parameter int unsigned SYMBOL_CYC = `EDL_SYMBOL_CYC,
  parameter int unsigned AVG_SYMBOLS = `EDL_AVG_SYMBOLS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire edl_pkg::edl_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sequence_enable_pin,
  input wire logic [7:0] power_sample,
  input wire logic rx_report_valid,
  input wire edl_pkg::edl_rx_report_t rx_report,
  output logic rx_on,
  output logic irq_n,
  output logic [7:0] synth_int_value,
  output logic [15:0] synth_frac_value,
  output logic [1:0] level_coarse,
  output logic [1:0] level_fine,
  output logic [1:0] drive_coarse,
  output logic [1:0] drive_fine,
  output logic stream_enable,
  output logic [15:0] stream_tune
);
  import edl_pkg::*;

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [15:0] ctrl_a_q;
  logic [15:0] ctrl_b_q;
  logic [15:0] synth_int_q;
  logic [15:0] synth_frac_q;
  logic [15:0] tx_level_q;
  logic [15:0] tune_q;
  logic cmpl_q;
  logic busy_q;
  logic [7:0] power_q;
  logic [6:0] length_q;
  edl_state_t state_q;
  logic [11:0] cnt_q;
  logic [3:0] sym_q;
  logic [10:0] sum_q;
  logic meas_done;
  logic status_rd;

  assign status_rd = reg_req.rd && (reg_req.addr == `EDL_ADDR_IRQ_STATUS);

  // Host writes; registers the host may keep streaming or tuning at will
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_a_q <= `EDL_RST_ZERO;
      ctrl_b_q <= `EDL_RST_ZERO;
      synth_int_q <= `EDL_RST_ZERO;
      synth_frac_q <= `EDL_RST_ZERO;
      tx_level_q <= `EDL_RST_TX_LEVEL; // R19
      tune_q <= `EDL_RST_STREAM_TUNE;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        `EDL_ADDR_CTRL_A: ctrl_a_q <= reg_req.wdata;
        `EDL_ADDR_CTRL_B: ctrl_b_q <= reg_req.wdata;
        `EDL_ADDR_SYNTH_INT: synth_int_q <= {8'h00, reg_req.wdata[7:0]};
        `EDL_ADDR_SYNTH_FRAC: synth_frac_q <= reg_req.wdata;
        `EDL_ADDR_TX_LEVEL: tx_level_q <= {8'h00, reg_req.wdata[7:0]}; // R19
        `EDL_ADDR_STREAM_TUNE: tune_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Measurement sequencer
  // ************************************************************
  logic start_ok;
  // Only the energy-detect algorithm runs here; other codes leave it idle
  assign start_ok = sequence_enable_pin
                    && (ctrl_a_q[`EDL_SEQ_LSB +: 2] == `EDL_SEQ_MEASURE)
                    && (ctrl_a_q[`EDL_ALGO_LSB +: 2] == `EDL_ALGO_ENERGY); // R6
  assign meas_done = (state_q == EDL_AVERAGE) && (cnt_q == 12'(SYMBOL_CYC - 1))
                     && (sym_q == 4'(AVG_SYMBOLS - 1));

  // Dropping the enable pin aborts at any point, so a stale run never reports
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= EDL_IDLE;
      cnt_q <= 12'h000;
      sym_q <= 4'h0;
      sum_q <= 11'h000;
    end else if (!sequence_enable_pin) begin
      state_q <= EDL_IDLE;
      cnt_q <= 12'h000;
    end else begin
      unique case (state_q)
        EDL_IDLE: begin
          cnt_q <= 12'h000;
          if (start_ok) begin
            state_q <= EDL_WARM;
          end
        end
        EDL_WARM: begin
          if (cnt_q == 12'(WARM_CYC - 1)) begin // R1
            state_q <= EDL_AVERAGE;
            cnt_q <= 12'h000;
            sym_q <= 4'h0;
            sum_q <= 11'h000;
          end else begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        EDL_AVERAGE: begin
          // One sample per symbol period keeps the adder narrow
          if (cnt_q == 12'(SYMBOL_CYC - 1)) begin // R1
            cnt_q <= 12'h000;
            sum_q <= sum_q + {3'h0, power_sample};
            sym_q <= sym_q + 4'h1;
            if (meas_done) begin
              state_q <= EDL_DONE;
            end
          end else begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        EDL_DONE: ;
      endcase
    end
  end

  // Receiver held on from warm-up through the averaging window
  // Start only counts from idle, else the receiver would stay on after the result
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_on <= 1'b0;
    end else begin
      rx_on <= sequence_enable_pin && ((state_q == EDL_IDLE && start_ok) || state_q == EDL_WARM
               || (state_q == EDL_AVERAGE && !meas_done)); // R1
    end
  end

  // ************************************************************
  // Result latch and status
  // ************************************************************
  logic [10:0] final_sum;
  assign final_sum = sum_q + {3'h0, power_sample};

  // Energy average or packet quality share one field; no threshold compare
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_q <= 8'h00;
      length_q <= 7'h00;
    end else if (meas_done && sequence_enable_pin) begin
      power_q <= final_sum[10:3]; // R2 R16
    end else if (rx_report_valid) begin
      power_q <= rx_report.quality; // R14 R16
      length_q <= rx_report.length; // R15
    end
  end

  // Completion is sticky; a new completion beats a clearing read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmpl_q <= 1'b0;
    end else if (meas_done && sequence_enable_pin) begin
      cmpl_q <= 1'b1; // R4
    end else if (status_rd) begin
      cmpl_q <= 1'b0; // R21
    end
  end

  // Busy flag belongs to threshold assessment, which is not built here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (status_rd) begin
      busy_q <= 1'b0; // R3 R21
    end
  end

  // Interrupt line, active low, gated by the completion enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !((cmpl_q || (meas_done && sequence_enable_pin))
                 && ctrl_a_q[`EDL_CMPL_EN_BIT]
                 && !(status_rd && !(meas_done && sequence_enable_pin))); // R5
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_req.addr)
      `EDL_ADDR_CTRL_A: rd_mux = ctrl_a_q;
      `EDL_ADDR_CTRL_B: rd_mux = ctrl_b_q;
      `EDL_ADDR_SYNTH_INT: rd_mux = synth_int_q;
      `EDL_ADDR_SYNTH_FRAC: rd_mux = synth_frac_q;
      `EDL_ADDR_TX_LEVEL: rd_mux = tx_level_q;
      `EDL_ADDR_STREAM_TUNE: rd_mux = tune_q;
      `EDL_ADDR_IRQ_STATUS: begin
        rd_mux[`EDL_CMPL_BIT] = cmpl_q;
        rd_mux[`EDL_BUSY_BIT] = busy_q;
      end
      // Quality and length come back in one word
      `EDL_ADDR_RX_LATCH: rd_mux = {power_q, 1'b0, length_q}; // R15
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data one cycle after the strobe; unmapped words read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Tuning outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      synth_int_value <= 8'h00;
      synth_frac_value <= 16'h0000;
      {level_coarse, level_fine, drive_coarse, drive_fine} <= 8'hbc;
      stream_enable <= 1'b0;
      stream_tune <= `EDL_RST_STREAM_TUNE;
    end else begin
      synth_int_value <= synth_int_q[7:0];
      synth_frac_value <= synth_frac_q;
      {level_coarse, level_fine, drive_coarse, drive_fine} <= tx_level_q[7:0]; // R19
      stream_enable <= ctrl_b_q[`EDL_STREAM_EN_BIT];
      stream_tune <= tune_q;
    end
  end
endmodule
`default_nettype wire

// File: verif/edl_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Host model
// ****
module edl_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  output var edl_pkg::edl_reg_req_t reg_req,
  output var logic sequence_enable_pin
);
  import edl_pkg::*;
  initial begin
    reg_req = '0;
    sequence_enable_pin = 1'b0;
  end
  // Released data is inverted so a stale word never looks valid
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    #1 reg_req.wr = 1'b0;
    reg_req.wdata = ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk);
    #1 reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(posedge clk);
    #1 reg_req.rd = 1'b0;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask
  // Pin low first; the pin also ends the previous sequence
  // Streaming may stay on, but then the tuning word must be set first
  task automatic measure(input logic [15:0] ctrl, input logic strm = 1'b0);
    sequence_enable_pin = 1'b0;
    wr(6'h0f, 16'h0042);
    wr(6'h10, 16'h1234);
    wr(6'h07, {10'h000, strm, 5'h00});
    if (strm) wr(6'h38, 16'h01ff);
    wr(6'h06, ctrl);
    @(posedge clk);
    #1 sequence_enable_pin = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verif/edl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module edl_monitor #(
  parameter int unsigned WARM_CYC = 20,
  parameter int unsigned SYMBOL_CYC = 10,
  parameter int unsigned AVG_SYMBOLS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire edl_pkg::edl_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic rx_on,
  input wire logic irq_n,
  input wire logic [1:0] level_coarse,
  input wire logic [1:0] level_fine,
  input wire logic [1:0] drive_coarse,
  input wire logic [1:0] drive_fine
);
  import edl_pkg::*;
  localparam int DONE_DLY = WARM_CYC + AVG_SYMBOLS * SYMBOL_CYC;
  logic en_q;
  logic [31:0] on_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the completion enable, so a masked irq can be told from a lost one
  always_ff @(posedge clk) begin
    if (!rst_n) en_q <= 1'b0;
    else if (reg_req.wr && reg_req.addr == 6'h06) en_q <= reg_req.wdata[10];
  end
  // Cycles the receiver has been on
  always_ff @(posedge clk) begin
    if (!rst_n) on_q <= '0;
    else on_q <= rx_on ? on_q + 32'h1 : '0;
  end
  a_rd_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read got no answer");
  a_read_clears: assert property (reg_req.rd && reg_req.addr == 6'h24 && !irq_n
    |-> ##[1:2] irq_n) else $error("status read left irq");
  a_status_done: assert property (reg_rvalid && $past(reg_req.addr) == 6'h24
    && $past(irq_n) == 1'b0 |-> reg_rdata[5]) else $error("done flag missing");
  a_busy_quiet: assert property (reg_rvalid && $past(reg_req.addr) == 6'h24
    |-> !reg_rdata[1]) else $error("busy flag set");
  a_done_time: assert property ($fell(irq_n) |-> on_q == DONE_DLY)
    else $error("completion at wrong time");
  a_irq_gated: assert property ($fell(irq_n) |-> en_q)
    else $error("irq while masked");
  a_rx_on_len: assert property (on_q <= DONE_DLY)
    else $error("receiver on too long");
  a_level_map: assert property (reg_req.wr && reg_req.addr == 6'h12
    |-> ##2 {level_coarse, level_fine, drive_coarse, drive_fine}
    == $past(reg_req.wdata[7:0], 2))
    else $error("level fields wrong");
endmodule
bind edl_top edl_monitor #(.WARM_CYC(WARM_CYC), .SYMBOL_CYC(SYMBOL_CYC),
  .AVG_SYMBOLS(AVG_SYMBOLS)) u_edl_monitor (.clk, .rst_n, .reg_req, .reg_rdata,
  .reg_rvalid, .rx_on, .irq_n, .level_coarse, .level_fine, .drive_coarse, .drive_fine);
`default_nettype wire

// File: verif/edl_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module edl_top_tb;
  import edl_pkg::*;
  localparam int W = 20;
  localparam int S = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxv = 1'b0;
  logic [7:0] ps = 8'h00;
  edl_rx_report_t rep = '0;
  edl_reg_req_t req;
  logic [15:0] rdata, d, e;
  logic rvalid, pin, rx_on, irq_n;
  logic [7:0] sint;
  logic [15:0] sfrac, stune;
  logic sen;
  int bad_count = 0;
  int check_count = 0;
  logic [15:0] exp_q[$];
  edl_top #(.WARM_CYC(W), .SYMBOL_CYC(S), .AVG_SYMBOLS(8)) u_edl_top (.clk, .rst_n,
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .sequence_enable_pin(pin),
    .power_sample(ps), .rx_report_valid(rxv), .rx_report(rep), .rx_on, .irq_n,
    .synth_int_value(sint), .synth_frac_value(sfrac), .level_coarse(), .level_fine(),
    .drive_coarse(), .drive_fine(), .stream_enable(sen), .stream_tune(stune));
  edl_host u_edl_host (.clk, .reg_rdata(rdata), .reg_req(req), .sequence_enable_pin(pin));
  // ****
  // Clock, watchdog, verdict
  // ****
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 5000);
    bad_count++;
    stop_test();
  end
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Constant power, so the average equals the sample
  task automatic run(input logic [15:0] ctrl, input logic strm = 1'b0);
    int n;
    n = 0;
    ps = 8'($urandom);
    exp_q.push_back({ps, 8'h00});
    u_edl_host.measure(ctrl, strm);
    while (irq_n !== 1'b0 && n < 150) begin
      @(posedge clk);
      #1 n++;
    end
    if (ctrl[10]) `CHK(n, W + 8 * S + 1)
    else `CHK(irq_n, 1'b1)
    `CHK({sint, sfrac}, 24'h421234)
    `CHK({sen, stune}, {strm, strm ? 16'h01ff : 16'h0008})
    u_edl_host.rd(6'h24, d);
    `CHK({d[5], d[1]}, 2'h2)
    `CHK(irq_n, 1'b1)
    u_edl_host.rd(6'h2d, d);
    e = exp_q.pop_front();
    `CHK(d[15:8], e[15:8])
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(94));
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    u_edl_host.rd(6'h12, d);
    `CHK(d, 16'h00bc)
    u_edl_host.rd(6'h3f, d);
    `CHK(d, 16'h0000)
    e = {8'h00, 4'($urandom), 4'hc};
    u_edl_host.wr(6'h12, e);
    u_edl_host.rd(6'h12, d);
    `CHK(d, {8'h00, e[7:0]})
    run(16'h0421);
    run(16'h0021, 1'b1);
    // Only the energy code may start the receiver
    for (int a = 0; a < 4; a++) begin
      if (a == 2) continue;
      u_edl_host.measure(16'h0401 | 16'(a << 4));
      repeat (W) @(posedge clk);
      `CHK(rx_on, 1'b0)
    end
    // Receive needs the default tuning word back
    u_edl_host.wr(6'h38, 16'h0008);
    // An 8-bit quality already spans 0..255, so host scaling is identity here
    rep = '{quality: 8'($urandom), length: 7'($urandom)};
    rxv = 1'b1;
    @(posedge clk);
    #1 rxv = 1'b0;
    `CHK(stune, 16'h0008)
    u_edl_host.rd(6'h2d, d);
    `CHK(d, {rep.quality, 1'b0, rep.length})
    stop_test();
  end
endmodule
`default_nettype wire
